// File: pkg/por_crc_pkg.sv
// constants for the power-on and configuration-check interrupt block
`default_nettype none
package por_crc_pkg;
    // serial framing, counted in sck falling edges after chip-select fall
    localparam logic [4:0] STATUS_LAST_FALL = 5'h08;
    localparam logic [4:0] IRQ_LAST_FALL = 5'h10;
    localparam logic [4:0] FALL_CNT_MAX = 5'h1F;
    localparam logic [3:0] IRQ_REG_ADDR = 4'h5;
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    // register-map checksum
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam int MAP_BYTES = 8;
    localparam int MAP_W = MAP_BYTES * 8;
    localparam logic [2:0] MAP_LAST = 3'h7;
    // pin synchroniser: bit0 avdd_ok, bit1 dvdd_ok, bit2 cs_n, bit3 sck
    localparam int SYNC_W = 4;
    localparam logic [3:0] SYNC_RST = 4'h4;
    // values after reset
    localparam logic POR_PEND_RST = 1'b1;
    localparam logic FLAG_IDLE_RST = 1'b1;
    localparam logic IRQ_PIN_RST = 1'b0;
endpackage
`default_nettype wire

// File: src/crc16_check.sv
// continuous CRC-16 walk over the register map image with mismatch pulse
`default_nettype none
module crc16_check (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    input wire logic [por_crc_pkg::MAP_W-1:0] map_flat,
    output logic mismatch
);
    import por_crc_pkg::*;

    logic [2:0] idx_ff;
    logic [15:0] crc_ff;
    logic [15:0] ref_ff;
    logic ref_ok_ff;
    logic mismatch_ff;
    logic [15:0] nxt_crc;
    logic [7:0] cur_byte;

    // msb-first byte update
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    assign cur_byte = map_flat[{idx_ff, 3'b000} +: 8];
    assign nxt_crc = crc16_byte(crc_ff, cur_byte);

    // first full pass after start becomes the reference; later passes compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_ff <= 3'h0;
            crc_ff <= CRC_INIT;
            ref_ff <= 16'h0000;
            ref_ok_ff <= 1'b0;
            mismatch_ff <= 1'b0;
        end else if (!run || restart) begin
            // halted or restarted: forget reference, start from scratch
            idx_ff <= 3'h0;
            crc_ff <= CRC_INIT;
            ref_ok_ff <= 1'b0;
            mismatch_ff <= 1'b0;
        end else begin
            mismatch_ff <= 1'b0;
            if (idx_ff == MAP_LAST) begin
                idx_ff <= 3'h0;
                crc_ff <= CRC_INIT;
                if (!ref_ok_ff) begin
                    ref_ff <= nxt_crc;
                    ref_ok_ff <= 1'b1;
                end else if (nxt_crc != ref_ff) begin
                    mismatch_ff <= 1'b1;
                end
            end else begin
                idx_ff <= idx_ff + 3'h1;
                crc_ff <= nxt_crc;
            end
        end
    end

    assign mismatch = mismatch_ff;

    AST_CRC_HALT: assert property (@(posedge clk) disable iff (!rst_n)
        !run |=> !mismatch_ff) else $error("checksum error while halted");
endmodule
`default_nettype wire

// File: src/pin_sync.sv
// two-flop synchroniser with falling-edge detect for outside pins
`default_nettype none
module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [por_crc_pkg::SYNC_W-1:0] din,
    output logic [por_crc_pkg::SYNC_W-1:0] level,
    output logic [por_crc_pkg::SYNC_W-1:0] fall
);
    import por_crc_pkg::*;

    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    logic [SYNC_W-1:0] prev_ff;

    // meta stage feeds only the second stage; edges use stages two and three
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= SYNC_RST;
            sync_ff <= SYNC_RST;
            prev_ff <= SYNC_RST;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign fall = prev_ff & ~sync_ff;
endmodule
`default_nettype wire

// File: src/por_and_config_crc_interrupts.sv
// power-on and configuration-check interrupt flags and interrupt pin
`default_nettype none
module por_and_config_crc_interrupts (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic avdd_ok,
    input wire logic dvdd_ok,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic addr_hit,
    input wire logic reg_read_start,
    input wire logic [3:0] reg_read_addr,
    input wire logic lock_wr,
    input wire logic [7:0] lock_data,
    input wire logic lock_active,
    input wire logic fast_restart,
    input wire logic [por_crc_pkg::MAP_W-1:0] map_flat,
    input wire logic irq_mode1,
    input wire logic modulator_bitstream_output_en,
    input wire logic modulator_bitstream_output_bit,
    input wire logic other_irq_n,
    output logic stat_por_n,
    output logic stat_cfg_n,
    output logic irqreg_por_n,
    output logic irqreg_cfg_n,
    output logic irq_n
);
    import por_crc_pkg::*;

    logic rst_meta_ff;
    logic rst_n_ff;
    logic rst_n;
    logic [SYNC_W-1:0] pin_lvl;
    logic [SYNC_W-1:0] pin_fall;
    logic supply_ok;
    logic cs_low;
    logic cs_fall;
    logic sck_fall;
    logic [4:0] fall_cnt_ff;
    logic status_done;
    logic irq_read_start;
    logic irq_rd_ff;
    logic irq_rd_done;
    logic crc_err;
    logic crc_run_ff;
    logic unlock;
    logic clear_cfg;
    logic stat_por_pend_ff;
    logic stat_cfg_pend_ff;
    logic irq_por_pend_ff;
    logic irq_cfg_pend_ff;
    logic por_pin_ff;
    logic cfg_pin_ff;
    logic por_req;
    logic cfg_req;
    logic stat_por_n_ff;
    logic stat_cfg_n_ff;
    logic irqreg_por_n_ff;
    logic irqreg_cfg_n_ff;
    logic irq_n_ff;
    logic nxt_irq_n;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_n_ff;

    // supply monitors and serial pins come from outside the mclk domain
    pin_sync u_pin_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din({sck, cs_n, dvdd_ok, avdd_ok}),
        .level(pin_lvl),
        .fall(pin_fall)
    );

    assign supply_ok = pin_lvl[0] & pin_lvl[1];
    assign cs_low = ~pin_lvl[2];
    assign cs_fall = pin_fall[2];
    assign sck_fall = pin_fall[3] & cs_low;

    // sck falling edges in the current frame, saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_ff <= 5'h00;
        end else if (cs_fall) begin
            fall_cnt_ff <= 5'h00;
        end else if (sck_fall && fall_cnt_ff != FALL_CNT_MAX) begin
            fall_cnt_ff <= fall_cnt_ff + 5'h01;
        end
    end

    // status byte is the first byte out, ends on its last falling edge
    assign status_done = sck_fall && (fall_cnt_ff == STATUS_LAST_FALL - 5'h01);

    // interrupt register read: single byte after the command byte
    assign irq_read_start = reg_read_start && (reg_read_addr == IRQ_REG_ADDR);
    assign irq_rd_done = irq_rd_ff && sck_fall && (fall_cnt_ff == IRQ_LAST_FALL - 5'h01);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_rd_ff <= 1'b0;
        end else if (irq_read_start) begin
            irq_rd_ff <= 1'b1;
        end else if (irq_rd_done || !cs_low) begin
            // an aborted frame leaves the flags pending for the next read
            irq_rd_ff <= 1'b0;
        end
    end

    // checksum runs only while locked; unlock key stops it through a register, one cycle later
    assign unlock = lock_wr && (lock_data == UNLOCK_KEY);
    assign clear_cfg = unlock || fast_restart;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            crc_run_ff <= 1'b0;
        end else begin
            crc_run_ff <= lock_active && !unlock;
        end
    end

    crc16_check u_crc16_check (
        .clk(mclk),
        .rst_n(rst_n),
        .run(crc_run_ff),
        .restart(fast_restart),
        .map_flat(map_flat),
        .mismatch(crc_err)
    );

    // status byte pending events; a new event beats the end-of-byte clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_por_pend_ff <= POR_PEND_RST;
            stat_cfg_pend_ff <= 1'b0;
        end else begin
            if (!supply_ok) begin
                stat_por_pend_ff <= 1'b1;
            end else if (status_done) begin
                stat_por_pend_ff <= 1'b0;
            end
            if (crc_err) begin
                stat_cfg_pend_ff <= 1'b1;
            end else if (status_done) begin
                stat_cfg_pend_ff <= 1'b0;
            end
        end
    end

    // status byte image latched on address recognition, idle after the byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_por_n_ff <= FLAG_IDLE_RST;
            stat_cfg_n_ff <= FLAG_IDLE_RST;
        end else if (addr_hit) begin
            stat_por_n_ff <= ~stat_por_pend_ff;
            stat_cfg_n_ff <= ~stat_cfg_pend_ff;
        end else if (status_done) begin
            stat_por_n_ff <= 1'b1;
            stat_cfg_n_ff <= 1'b1;
        end
    end

    // interrupt register pending events, set wins over the read clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_por_pend_ff <= POR_PEND_RST;
            irq_cfg_pend_ff <= 1'b0;
        end else begin
            if (!supply_ok) begin
                irq_por_pend_ff <= 1'b1;
            end else if (irq_rd_done) begin
                irq_por_pend_ff <= 1'b0;
            end
            if (crc_err) begin
                irq_cfg_pend_ff <= 1'b1;
            end else if (irq_rd_done) begin
                irq_cfg_pend_ff <= 1'b0;
            end
        end
    end

    // interrupt register image latched at read start, idle after the read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irqreg_por_n_ff <= FLAG_IDLE_RST;
            irqreg_cfg_n_ff <= FLAG_IDLE_RST;
        end else if (irq_read_start) begin
            irqreg_por_n_ff <= ~irq_por_pend_ff;
            irqreg_cfg_n_ff <= ~irq_cfg_pend_ff;
        end else if (irq_rd_done) begin
            irqreg_por_n_ff <= 1'b1;
            irqreg_cfg_n_ff <= 1'b1;
        end
    end

    // pin power-on source: held while any supply is low, freed by cs fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            por_pin_ff <= POR_PEND_RST;
        end else if (!supply_ok) begin
            por_pin_ff <= 1'b1;
        end else if (cs_fall) begin
            por_pin_ff <= 1'b0;
        end
    end

    // pin config-check source: only unlock or restart clears it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_pin_ff <= 1'b0;
        end else if (crc_err) begin
            cfg_pin_ff <= 1'b1;
        end else if (clear_cfg) begin
            cfg_pin_ff <= 1'b0;
        end
    end

    // set terms feed the pin directly so a supply drop costs one cycle only
    assign por_req = por_pin_ff | ~supply_ok;
    assign cfg_req = cfg_pin_ff | crc_err;

    // priority: power-on, config-check, bitstream, then the other sources unless irq_mode1 holds the pin high
    always_comb begin
        if (por_req) begin
            nxt_irq_n = 1'b0;
        end else if (cfg_req) begin
            nxt_irq_n = 1'b0;
        end else if (modulator_bitstream_output_en) begin
            nxt_irq_n = modulator_bitstream_output_bit;
        end else if (irq_mode1) begin
            nxt_irq_n = 1'b1;
        end else begin
            nxt_irq_n = other_irq_n;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_ff <= IRQ_PIN_RST;
        end else begin
            irq_n_ff <= nxt_irq_n;
        end
    end

    assign stat_por_n = stat_por_n_ff;
    assign stat_cfg_n = stat_cfg_n_ff;
    assign irqreg_por_n = irqreg_por_n_ff;
    assign irqreg_cfg_n = irqreg_cfg_n_ff;
    assign irq_n = irq_n_ff;

    AST_PIN_POR_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
        !supply_ok |=> !irq_n_ff) else $error("pin not low on supply drop");

    AST_POR_PIN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        por_pin_ff && !(cs_fall && supply_ok) |=> por_pin_ff)
        else $error("power-on pin source dropped early");

    AST_POR_PIN_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
        por_pin_ff && cs_fall && supply_ok |=> !por_pin_ff)
        else $error("power-on pin source not released");

    AST_CFG_PIN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_pin_ff && !clear_cfg |=> cfg_pin_ff)
        else $error("config-check pin source dropped");

    AST_CFG_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
        clear_cfg && !crc_err |=> !cfg_pin_ff) else $error("config-check not cleared");

    AST_CRC_ERR_SETS: assert property (@(posedge mclk) disable iff (!rst_n)
        crc_err |=> cfg_pin_ff && irq_cfg_pend_ff && stat_cfg_pend_ff)
        else $error("checksum error not recorded");

    AST_STAT_AFTER_BYTE: assert property (@(posedge mclk) disable iff (!rst_n)
        status_done && !addr_hit |=> stat_por_n_ff && stat_cfg_n_ff)
        else $error("status flags not idle after byte");

    AST_STAT_POR_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
        addr_hit && stat_por_pend_ff |=> !stat_por_n_ff)
        else $error("pending power-on not shown in status");

    AST_IRQREG_POR_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_read_start && irq_por_pend_ff |=> !irqreg_por_n_ff)
        else $error("pending power-on not shown in register");

    AST_IRQREG_DONE: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_rd_done && !irq_read_start |=> irqreg_por_n_ff && irqreg_cfg_n_ff)
        else $error("register flags not idle after read");

    AST_MODE_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_mode1 && !modulator_bitstream_output_en && !por_req && !cfg_req && !other_irq_n |=> irq_n_ff)
        else $error("other source pulled pin in restricted mode");

    AST_CFG_OVER_MODULATOR_BITSTREAM_OUTPUT: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_req && modulator_bitstream_output_en && modulator_bitstream_output_bit |=> !irq_n_ff)
        else $error("bitstream overrode config-check");
endmodule
`default_nettype wire

// File: verification/host_model.sv
// host side serial model: chip select and link clock frames
`default_nettype none
module host_model (
    output logic cs_n,
    output logic sck
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 80;
    // link clock idles low and stands still between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
    end
    // one frame: select, n link clock pulses, deselect
    // a frame of zero pulses is the host polling power-up via the pin
    task frame(input int n);
        #40;
        cs_n = 1'b0;
        repeat (n) begin
            #HALF;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
        #HALF;
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: verification/test_por_and_config_crc_interrupts.sv
// self-checking bench for the power-on and config-check interrupt block
`default_nettype none
module test_por_and_config_crc_interrupts;
    timeunit 1ns;
    timeprecision 100ps;
    import por_crc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic avdd_ok = 1'b1;
    logic dvdd_ok = 1'b1;
    logic addr_hit = 1'b0;
    logic reg_read_start = 1'b0;
    logic [3:0] reg_read_addr = 4'h0;
    logic lock_wr = 1'b0;
    logic [7:0] lock_data = 8'h00;
    logic lock_active = 1'b0;
    logic fast_restart = 1'b0;
    logic [MAP_W-1:0] map_flat = 64'h0123456789ABCDEF;
    logic irq_mode1 = 1'b0;
    logic modulator_bitstream_output_en = 1'b0;
    logic modulator_bitstream_output_bit = 1'b0;
    logic other_irq_n = 1'b1;
    wire logic cs_n;
    wire logic sck;
    logic stat_por_n, stat_cfg_n, irqreg_por_n, irqreg_cfg_n, irq_n;
    logic sp, sc, rp, rc;
    logic [3:0] rd_addr = IRQ_REG_ADDR;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    // 250 MHz core clock
    always #2 mclk = ~mclk;

    host_model i_host_model (.cs_n(cs_n), .sck(sck));

    por_and_config_crc_interrupts i_por_and_config_crc_interrupts (
        .mclk(mclk), .nrst(nrst), .avdd_ok(avdd_ok), .dvdd_ok(dvdd_ok),
        .cs_n(cs_n), .sck(sck), .addr_hit(addr_hit), .reg_read_start(reg_read_start),
        .reg_read_addr(reg_read_addr), .lock_wr(lock_wr), .lock_data(lock_data),
        .lock_active(lock_active), .fast_restart(fast_restart), .map_flat(map_flat),
        .irq_mode1(irq_mode1), .modulator_bitstream_output_en(modulator_bitstream_output_en), .modulator_bitstream_output_bit(modulator_bitstream_output_bit),
        .other_irq_n(other_irq_n), .stat_por_n(stat_por_n), .stat_cfg_n(stat_cfg_n),
        .irqreg_por_n(irqreg_por_n), .irqreg_cfg_n(irqreg_cfg_n), .irq_n(irq_n)
    );

    task report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // cut a hang short; generous against roughly 5.4k cycles of tests
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // bounded wait on the pin, then compare
    task automatic wait_irq(input logic exp, input int limit);
        int k;
        k = 0;
        while (irq_n !== exp && k < limit) begin
            @(negedge mclk);
            k++;
        end
        check("irq_n", irq_n, exp);
    endtask

    // one host frame; status and register images sampled mid-frame
    task automatic xfer(input int n, input logic hit, input logic rd);
        fork
            i_host_model.frame(n);
            begin
                @(negedge cs_n);
                repeat (8) @(negedge mclk);
                addr_hit = hit;
                reg_read_start = rd;
                reg_read_addr = rd_addr;
                @(negedge mclk);
                addr_hit = 1'b0;
                reg_read_start = 1'b0;
                repeat (2) @(negedge mclk);
                sp = stat_por_n;
                sc = stat_cfg_n;
                rp = irqreg_por_n;
                rc = irqreg_cfg_n;
            end
        join
        repeat (8) @(negedge mclk);
    endtask

    // corrupt one map byte until the checker fires, then put it back
    task automatic corrupt_map;
        map_flat[7:0] = ~map_flat[7:0];
        wait_irq(1'b0, 60);
        map_flat[7:0] = ~map_flat[7:0];
        repeat (30) @(negedge mclk);
    endtask

    task automatic pulse_lock(input logic [7:0] key);
        lock_data = key;
        lock_wr = 1'b1;
        @(negedge mclk);
        lock_wr = 1'b0;
    endtask

    initial begin
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        repeat (12) @(negedge mclk);
        // power-up flags on all three paths
        check("irq_n", irq_n, 1'b0);
        xfer(16, 1'b1, 1'b1);
        check("stat_por_n", sp, 1'b0);
        check("irqreg_por_n", rp, 1'b0);
        check("stat_cfg_n", sc, 1'b1);
        check("irqreg_cfg_n", rc, 1'b1);
        check("stat_por_n", stat_por_n, 1'b1);
        check("irqreg_por_n", irqreg_por_n, 1'b1);
        check("irq_n", irq_n, 1'b1);
        xfer(16, 1'b1, 1'b1);
        check("stat_por_n", sp, 1'b1);
        check("irqreg_por_n", rp, 1'b1);
        $display("test power_up done");
        // supply drop, partial recovery, full recovery
        avdd_ok = 1'b0;
        wait_irq(1'b0, 12);
        avdd_ok = 1'b1;
        dvdd_ok = 1'b0;
        repeat (10) @(negedge mclk);
        xfer(0, 1'b0, 1'b0);
        check("irq_n", irq_n, 1'b0);
        dvdd_ok = 1'b1;
        modulator_bitstream_output_en = 1'b1;
        modulator_bitstream_output_bit = 1'b1;
        repeat (10) @(negedge mclk);
        check("irq_n", irq_n, 1'b0);
        xfer(16, 1'b1, 1'b1);
        check("stat_por_n", sp, 1'b0);
        check("irqreg_por_n", rp, 1'b0);
        check("irq_n", irq_n, 1'b1);
        modulator_bitstream_output_bit = 1'b0;
        repeat (3) @(negedge mclk);
        check("irq_n", irq_n, 1'b0);
        modulator_bitstream_output_en = 1'b0;
        other_irq_n = 1'b0;
        repeat (3) @(negedge mclk);
        check("irq_n", irq_n, 1'b0);
        irq_mode1 = 1'b1;
        repeat (3) @(negedge mclk);
        check("irq_n", irq_n, 1'b1);
        irq_mode1 = 1'b0;
        other_irq_n = 1'b1;
        $display("test supply_drop done");
        // config-check error, its flags, restart and unlock clears
        lock_active = 1'b1;
        repeat (40) @(negedge mclk);
        check("irq_n", irq_n, 1'b1);
        corrupt_map();
        modulator_bitstream_output_en = 1'b1;
        modulator_bitstream_output_bit = 1'b1;
        repeat (3) @(negedge mclk);
        check("irq_n", irq_n, 1'b0);
        modulator_bitstream_output_en = 1'b0;
        xfer(16, 1'b1, 1'b1);
        check("stat_cfg_n", sc, 1'b0);
        check("irqreg_cfg_n", rc, 1'b0);
        check("stat_cfg_n", stat_cfg_n, 1'b1);
        check("irqreg_cfg_n", irqreg_cfg_n, 1'b1);
        check("irq_n", irq_n, 1'b0);
        xfer(16, 1'b1, 1'b1);
        check("stat_cfg_n", sc, 1'b1);
        check("irqreg_cfg_n", rc, 1'b1);
        fast_restart = 1'b1;
        @(negedge mclk);
        fast_restart = 1'b0;
        wait_irq(1'b1, 10);
        repeat (40) @(negedge mclk);
        check("irq_n", irq_n, 1'b1);
        corrupt_map();
        // a read of another address and a cut read both leave the flag pending
        rd_addr = 4'h4;
        xfer(16, 1'b1, 1'b1);
        check("irqreg_cfg_n", rc, 1'b1);
        check("stat_cfg_n", sc, 1'b0);
        rd_addr = IRQ_REG_ADDR;
        xfer(8, 1'b1, 1'b1);
        check("irqreg_cfg_n", rc, 1'b0);
        check("stat_cfg_n", sc, 1'b1);
        check("irqreg_cfg_n", irqreg_cfg_n, 1'b0);
        xfer(16, 1'b1, 1'b1);
        check("irqreg_cfg_n", rc, 1'b0);
        check("irqreg_cfg_n", irqreg_cfg_n, 1'b1);
        pulse_lock(8'h5A);
        repeat (5) @(negedge mclk);
        check("irq_n", irq_n, 1'b0);
        lock_active = 1'b0;
        pulse_lock(UNLOCK_KEY);
        wait_irq(1'b1, 10);
        repeat (40) @(negedge mclk);
        check("irq_n", irq_n, 1'b1);
        $display("test config_check done");
        report_and_stop();
    end
endmodule
`default_nettype wire
